/* design/mic_dsp_cfg_pkg.sv */
package mic_dsp_cfg_pkg;

	// ------------------------------------------------------------
	// register offsets on the control port
	// ------------------------------------------------------------
	localparam logic [7:0] chan4_gain_trim_addr = 8'h4e;
	localparam logic [7:0] chan4_phase_trim_addr = 8'h4f;
	localparam logic [7:0] dsp_config_first_addr = 8'h6b;
	localparam logic [7:0] dsp_config_second_addr = 8'h6c;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] chan4_gain_trim_rst = 8'h80;
	localparam logic [7:0] chan4_phase_trim_rst = 8'h00;
	localparam logic [7:0] dsp_config_first_rst = 8'h01;
	localparam logic [7:0] dsp_config_second_rst = 8'h40;

	// ------------------------------------------------------------
	// writable bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] chan4_gain_trim_wmask = 8'hf0;
	localparam logic [7:0] full_byte_wmask = 8'hff;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int gain_trim_lsb = 4;
	localparam int decimation_response_lsb = 4;
	localparam int channel_averaging_mode_lsb = 2;
	localparam int highpass_choice_lsb = 0;
	localparam int volume_tie_all_bit = 7;
	localparam int biquad_count_lsb = 5;
	localparam int soft_step_off_bit = 4;

	// ------------------------------------------------------------
	// field codes
	// ------------------------------------------------------------
	localparam logic [3:0] gain_trim_zero_db_code = 4'h8;
	localparam logic [1:0] decim_linear_code = 2'h0;
	localparam logic [1:0] decim_low_latency_code = 2'h1;
	localparam logic [1:0] decim_ultra_low_code = 2'h2;
	localparam logic [1:0] averaging_on_code = 2'h1;
	localparam logic [1:0] highpass_iir_code = 2'h0;

endpackage : mic_dsp_cfg_pkg

/* design/cfg_byte_reg.sv */
`timescale 1ns/1ps

// one configuration byte; bits outside the mask hold their reset value
module cfg_byte_reg
	import mic_dsp_cfg_pkg::*;
#(
	parameter logic [7:0] reset_value = 8'h00,
	parameter logic [7:0] write_mask = 8'hff
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic write_en,
	input wire logic [7:0] write_data,
	output logic [7:0] value
);

	// ------------------------------------------------------------
	// merge of written and fixed bits
	// ------------------------------------------------------------
	wire [7:0] next_value = (write_data & write_mask)
		| (reset_value & ~write_mask);

	// storage
	always_ff @(posedge mclk)
	begin
		if (rst)
			value <= reset_value;
		else if (write_en)
			value <= next_value;
	end

endmodule : cfg_byte_reg

/* design/mic_channel_dsp_config_regs.sv */
`timescale 1ns/1ps

module mic_channel_dsp_config_regs
	import mic_dsp_cfg_pkg::*;
#(
	parameter int channels = 4,
	parameter int biquad_stages = 3
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_write,
	input wire logic cfg_read,
	output logic [7:0] cfg_rdata,
	output logic signed [4:0] gain_trim_tenths_db,
	output logic [7:0] phase_delay_cycles,
	output logic decim_linear,
	output logic decim_low_latency,
	output logic decim_ultra_low,
	output logic average_ch12,
	output logic highpass_programmable,
	output logic [1:0] highpass_fixed_cutoff,
	output logic [biquad_stages-1:0] biquad_stage_en,
	output logic volume_tie_all,
	output logic [channels-1:0] volume_from_ch1,
	output logic soft_step_enable
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire hit_gain = cfg_addr == chan4_gain_trim_addr;
	wire hit_phase = cfg_addr == chan4_phase_trim_addr;
	wire hit_first = cfg_addr == dsp_config_first_addr;
	wire hit_second = cfg_addr == dsp_config_second_addr;

	logic [7:0] chan4_gain_trim;
	logic [7:0] chan4_phase_trim;
	logic [7:0] dsp_config_first;
	logic [7:0] dsp_config_second;

	// ------------------------------------------------------------
	// register cells
	// ------------------------------------------------------------
	// low nibble masked off so it can never hold a one
	cfg_byte_reg #(
		.reset_value(chan4_gain_trim_rst),
		.write_mask(chan4_gain_trim_wmask)
	) u_gain (
		.mclk(mclk),
		.rst(rst),
		.write_en(cfg_write && hit_gain),
		.write_data(cfg_wdata),
		.value(chan4_gain_trim)
	);

	cfg_byte_reg #(
		.reset_value(chan4_phase_trim_rst),
		.write_mask(full_byte_wmask)
	) u_phase (
		.mclk(mclk),
		.rst(rst),
		.write_en(cfg_write && hit_phase),
		.write_data(cfg_wdata),
		.value(chan4_phase_trim)
	);

	// reserved bits stay writable; software keeps them at zero
	cfg_byte_reg #(
		.reset_value(dsp_config_first_rst),
		.write_mask(full_byte_wmask)
	) u_first (
		.mclk(mclk),
		.rst(rst),
		.write_en(cfg_write && hit_first),
		.write_data(cfg_wdata),
		.value(dsp_config_first)
	);

	cfg_byte_reg #(
		.reset_value(dsp_config_second_rst),
		.write_mask(full_byte_wmask)
	) u_second (
		.mclk(mclk),
		.rst(rst),
		.write_en(cfg_write && hit_second),
		.write_data(cfg_wdata),
		.value(dsp_config_second)
	);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// unmapped offsets answer zero
	wire [7:0] next_rdata =
		hit_gain ? chan4_gain_trim :
		hit_phase ? chan4_phase_trim :
		hit_first ? dsp_config_first :
		hit_second ? dsp_config_second : 8'h00;

	// read data held until the next read
	always_ff @(posedge mclk)
	begin
		if (rst)
			cfg_rdata <= 8'h00;
		else if (cfg_read)
			cfg_rdata <= next_rdata;
	end

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	wire [3:0] gain_code = chan4_gain_trim[gain_trim_lsb +: 4];
	wire [1:0] decim_sel =
		dsp_config_first[decimation_response_lsb +: 2];
	wire [1:0] avg_sel =
		dsp_config_first[channel_averaging_mode_lsb +: 2];
	wire [1:0] hp_sel = dsp_config_first[highpass_choice_lsb +: 2];
	wire [1:0] bq_count = dsp_config_second[biquad_count_lsb +: 2];
	wire tie_bit = dsp_config_second[volume_tie_all_bit];
	wire soft_off = dsp_config_second[soft_step_off_bit];

	// signed offset in tenths of a dB: code minus the 0 dB code
	wire signed [4:0] next_gain =
		$signed({1'b0, gain_code}) -
		$signed({1'b0, gain_trim_zero_db_code});

	// reserved decimation code 3 enables no response at all
	wire next_decim_linear = decim_sel == decim_linear_code;
	wire next_decim_low = decim_sel == decim_low_latency_code;
	wire next_decim_ultra = decim_sel == decim_ultra_low_code;

	// only code 1 averages; reserved codes fall back to off
	wire next_average = avg_sel == averaging_on_code;

	// code 0 routes through the programmable all-pass-default iir
	wire next_hp_prog = hp_sel == highpass_iir_code;

	// ------------------------------------------------------------
	// control levels at reset
	// ------------------------------------------------------------
	// decoded from the register reset bytes, so the outputs can never
	// disagree with what a read returns straight after reset; changing
	// a reset byte in the package moves both together
	wire [3:0] reset_gain_code =
		chan4_gain_trim_rst[gain_trim_lsb +: 4];
	wire [1:0] reset_decim_sel =
		dsp_config_first_rst[decimation_response_lsb +: 2];
	wire [1:0] reset_avg_sel =
		dsp_config_first_rst[channel_averaging_mode_lsb +: 2];
	wire [1:0] reset_hp_sel =
		dsp_config_first_rst[highpass_choice_lsb +: 2];
	wire [1:0] reset_bq_count =
		dsp_config_second_rst[biquad_count_lsb +: 2];
	wire reset_tie_bit = dsp_config_second_rst[volume_tie_all_bit];
	wire reset_soft_off = dsp_config_second_rst[soft_step_off_bit];

	// same arithmetic as the live path, applied to the reset code
	wire signed [4:0] reset_gain =
		$signed({1'b0, reset_gain_code}) -
		$signed({1'b0, gain_trim_zero_db_code});
	wire reset_decim_linear = reset_decim_sel == decim_linear_code;
	wire reset_decim_low = reset_decim_sel == decim_low_latency_code;
	wire reset_decim_ultra = reset_decim_sel == decim_ultra_low_code;
	wire reset_average = reset_avg_sel == averaging_on_code;
	wire reset_hp_prog = reset_hp_sel == highpass_iir_code;

	// ------------------------------------------------------------
	// datapath control flops
	// ------------------------------------------------------------
	// one cycle behind the register so the datapath sees clean levels;
	// the extra cycle is harmless for settings that rarely change
	always_ff @(posedge mclk)
	begin
		if (rst)
			gain_trim_tenths_db <= reset_gain;
		else
			gain_trim_tenths_db <= next_gain;
	end

	// phase delay count handed on unchanged, 0 meaning no delay
	always_ff @(posedge mclk)
	begin
		if (rst)
			phase_delay_cycles <= chan4_phase_trim_rst;
		else
			phase_delay_cycles <= chan4_phase_trim;
	end

	// decimation response as three one-hot selects
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			decim_linear <= reset_decim_linear;
			decim_low_latency <= reset_decim_low;
			decim_ultra_low <= reset_decim_ultra;
		end
		else
		begin
			decim_linear <= next_decim_linear;
			decim_low_latency <= next_decim_low;
			decim_ultra_low <= next_decim_ultra;
		end
	end

	// two-channel averaging select
	always_ff @(posedge mclk)
	begin
		if (rst)
			average_ch12 <= reset_average;
		else
			average_ch12 <= next_average;
	end

	// raw code travels along with the programmable flag, so the filter
	// picks its fixed coefficients without decoding the register again
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			highpass_programmable <= reset_hp_prog;
			highpass_fixed_cutoff <= reset_hp_sel;
		end
		else
		begin
			highpass_programmable <= next_hp_prog;
			highpass_fixed_cutoff <= hp_sel;
		end
	end

	// volume tie
	always_ff @(posedge mclk)
	begin
		if (rst)
			volume_tie_all <= reset_tie_bit;
		else
			volume_tie_all <= tie_bit;
	end

	// soft step is the inverse of the disable bit
	always_ff @(posedge mclk)
	begin
		if (rst)
			soft_step_enable <= !reset_soft_off;
		else
			soft_step_enable <= !soft_off;
	end

	// ------------------------------------------------------------
	// per-stage and per-channel enables
	// ------------------------------------------------------------
	// stage i runs when the count exceeds i; count 0 stops them all
	// channel one always uses its own volume, so the tie is moot there;
	// channels that are switched off simply ignore their select
	genvar gi;
	generate
		for (gi = 0; gi < biquad_stages; gi++)
		begin : g_bq
			wire next_en = 32'(bq_count) > gi;
			wire reset_en = 32'(reset_bq_count) > gi;
			always_ff @(posedge mclk)
			begin
				if (rst)
					biquad_stage_en[gi] <= reset_en;
				else
					biquad_stage_en[gi] <= next_en;
			end
		end
		for (gi = 0; gi < channels; gi++)
		begin : g_vol
			always_ff @(posedge mclk)
			begin
				if (rst)
					volume_from_ch1[gi] <= reset_tie_bit || gi == 0;
				else
					volume_from_ch1[gi] <= tie_bit || gi == 0;
			end
		end
	endgenerate

endmodule : mic_channel_dsp_config_regs

/* dv/mic_dsp_cfg_asserts.sv */
`timescale 1ns/1ps

module mic_dsp_cfg_asserts
#(
	parameter int channels = 4,
	parameter int biquad_stages = 3
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_rdata,
	input wire logic signed [4:0] gain_trim_tenths_db,
	input wire logic [7:0] phase_delay_cycles,
	input wire logic decim_linear,
	input wire logic decim_low_latency,
	input wire logic decim_ultra_low,
	input wire logic average_ch12,
	input wire logic highpass_programmable,
	input wire logic [1:0] highpass_fixed_cutoff,
	input wire logic [biquad_stages-1:0] biquad_stage_en,
	input wire logic volume_tie_all,
	input wire logic [channels-1:0] volume_from_ch1,
	input wire logic soft_step_enable
);
	// write data two edges back, since controls trail a write by two edges
	logic [7:0] w1, w2;
	always_ff @(posedge mclk)
	begin
		w1 <= cfg_wdata;
		w2 <= w1;
	end
	wire logic g = cfg_write && cfg_addr == 8'h4e;
	wire logic p = cfg_write && cfg_addr == 8'h4f;
	wire logic c0 = cfg_write && cfg_addr == 8'h6b;
	wire logic c1 = cfg_write && cfg_addr == 8'h6c;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_GAIN: assert property (g |-> ##2
		gain_trim_tenths_db == {1'h0, w2[7:4]} - 5'h8) else $error("gain");
	AST_GAIN_LOW: assert property (
		cfg_read && cfg_addr == 8'h4e |=> cfg_rdata[3:0] == 4'h0)
		else $error("gain low bits");
	AST_PHASE: assert property (p |-> ##2 phase_delay_cycles == w2)
		else $error("phase");
	AST_DECIM: assert property (c0 |-> ##2 {decim_linear,
		decim_low_latency, decim_ultra_low} == {w2[5:4] == 2'h0,
		w2[5:4] == 2'h1, w2[5:4] == 2'h2}) else $error("decim");
	AST_HPF: assert property (c0 |-> ##2
		highpass_fixed_cutoff == w2[1:0] &&
		highpass_programmable == (w2[1:0] == 2'h0)) else $error("hpf");
	AST_BIQUAD: assert property (c1 |-> ##2 biquad_stage_en ==
		{w2[6] & w2[5], w2[6], w2[6] | w2[5]}) else $error("biquad");
	AST_TIE: assert property (c1 |-> ##2 volume_tie_all == w2[7] &&
		volume_from_ch1 == ({channels{w2[7]}} | 1'h1)) else $error("tie");
	AST_SOFT: assert property (c1 |-> ##2 soft_step_enable == !w2[4])
		else $error("soft step");
	// main scenarios reached
	COV_FIRST: cover property (c0 ##2 decim_ultra_low);
	COV_SECOND: cover property (c1 ##2 !soft_step_enable);
	COV_READ: cover property (cfg_read && cfg_addr == 8'h4e);
endmodule : mic_dsp_cfg_asserts

bind mic_channel_dsp_config_regs mic_dsp_cfg_asserts #(.channels(channels),
	.biquad_stages(biquad_stages)) u_mic_dsp_cfg_asserts (.mclk, .rst,
	.cfg_addr, .cfg_wdata, .cfg_write, .cfg_read, .cfg_rdata,
	.gain_trim_tenths_db, .phase_delay_cycles, .decim_linear,
	.decim_low_latency, .decim_ultra_low, .average_ch12,
	.highpass_programmable, .highpass_fixed_cutoff, .biquad_stage_en,
	.volume_tie_all, .volume_from_ch1, .soft_step_enable);

/* dv/mic_channel_dsp_config_regs_tb_top.sv */
`timescale 1ns/1ps

module mic_channel_dsp_config_regs_tb_top;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic cfg_write = 1'h0;
	logic cfg_read = 1'h0;
	logic [7:0] cfg_addr = 8'h00;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] cfg_rdata, phase_delay_cycles;
	logic signed [4:0] gain_trim_tenths_db;
	logic decim_linear, decim_low_latency, decim_ultra_low, average_ch12;
	logic highpass_programmable, volume_tie_all, soft_step_enable;
	logic [1:0] highpass_fixed_cutoff;
	logic [2:0] biquad_stage_en;
	logic [3:0] volume_from_ch1;
	int mismatches = 0;
	int samples_checked = 0;
	// controls packed in bytes; soft_step_enable rides in dsp_a though the second register sets it
	wire logic [7:0] dsp_a = {decim_linear, decim_low_latency, decim_ultra_low,
		average_ch12, highpass_programmable, highpass_fixed_cutoff,
		soft_step_enable};
	wire logic [7:0] dsp_b = {biquad_stage_en, volume_tie_all, volume_from_ch1};
	// free-running 100 MHz clock
	always #5 mclk = ~mclk;
	mic_channel_dsp_config_regs u_mic_channel_dsp_config_regs (.mclk, .rst,
		.cfg_addr, .cfg_wdata, .cfg_write, .cfg_read, .cfg_rdata,
		.gain_trim_tenths_db, .phase_delay_cycles, .decim_linear,
		.decim_low_latency, .decim_ultra_low, .average_ch12,
		.highpass_programmable, .highpass_fixed_cutoff, .biquad_stage_en,
		.volume_tie_all, .volume_from_ch1, .soft_step_enable);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one-cycle strobe, then one more edge so the controls have landed
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk);
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_write <= 1'h1;
		@(posedge mclk);
		cfg_write <= 1'h0;
		@(posedge mclk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		cfg_addr <= a;
		cfg_read <= 1'h1;
		@(posedge mclk);
		cfg_read <= 1'h0;
		#1;
	endtask : rd
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values;
		rd(8'h4e);
		chk("gain reg", 8'h80, cfg_rdata);
		rd(8'h4f);
		chk("phase reg", 8'h00, cfg_rdata);
		rd(8'h6b);
		chk("first reg", 8'h01, cfg_rdata);
		rd(8'h6c);
		chk("second reg", 8'h40, cfg_rdata);
		chk("gain", 8'h00, 8'(gain_trim_tenths_db));
		chk("first ctl", 8'h83, dsp_a);
		chk("second ctl", 8'h61, dsp_b);
	endtask : reset_values
	// both ends of the gain code; reserved low nibble written as zero
	task automatic trims;
		wr(8'h4e, 8'hf0);
		chk("gain", 8'h07, 8'(gain_trim_tenths_db));
		rd(8'h4e);
		chk("gain reg", 8'hf0, cfg_rdata);
		wr(8'h4e, 8'h00);
		chk("gain", 8'hf8, 8'(gain_trim_tenths_db));
		wr(8'h4f, 8'hff);
		chk("phase", 8'hff, phase_delay_cycles);
		rd(8'h4f);
		chk("phase reg", 8'hff, cfg_rdata);
	endtask : trims
	// every legal code of the three fields; reserved codes never written
	task automatic first_config;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h6b, 8'(i % 3 * 16 + i % 2 * 4 + i));
			chk("first ctl", {i % 3 == 0, i % 3 == 1, i % 3 == 2, i % 2 == 1,
				i == 0, 2'(i), 1'h1}, dsp_a);
		end
	endtask : first_config
	task automatic second_config;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h6c, 8'(i * 32 + i % 2 * 128 + i / 2 * 16));
			chk("second ctl", {i == 3, i > 1, i > 0, {5{i % 2 == 1}}} | 8'h01,
				dsp_b);
			chk("soft step", {7'h0, i < 2}, {7'h0, soft_step_enable});
		end
		rd(8'h6c);
		chk("second reg", 8'hf0, cfg_rdata);
	endtask : second_config
	// main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		reset_values();
		trims();
		first_config();
		second_config();
		print_verdict();
	end
	// watchdog, far beyond the fifty or so cycles the tests need
	initial
	begin
		#20000;
		mismatches++;
		print_verdict();
	end
endmodule : mic_channel_dsp_config_regs_tb_top
